// file: verilog/pgb_defines.vh
/*
 Register offsets, field positions, reset values and sizes of the PWM generator slice.
 Assumes inclusion by bare name from the slice's design file.
*/
`ifndef PGB_DEFINES_VH
`define PGB_DEFINES_VH

// Byte offsets on the register bus
`define PGB_OFS_PCI_CTRL_HIGH   12'h000
`define PGB_OFS_BLANK_PERIOD    12'h004
`define PGB_OFS_BLANK_EDGE_SEL  12'h008
`define PGB_OFS_PHASE           12'h00c
`define PGB_OFS_DUTY            12'h010
`define PGB_OFS_DUTY_ADJ        12'h014
`define PGB_OFS_PERIOD          12'h018
`define PGB_OFS_STATUS          12'h01c

// Reset value of every register
`define PGB_RST_VAL             16'h0000

// Protection input control high fields
`define PGB_TQ_SRC_LSB          0
`define PGB_TQ_POL_BIT          3
`define PGB_SWPC_TARGET_LSB     5
`define PGB_SWPC_BIT            7
`define PGB_SWPC_TARGET_TQ      2'h2

// Termination qualifier source codes
`define PGB_TQ_NONE             3'h0
`define PGB_TQ_DUTY             3'h1
`define PGB_TQ_BLANK            3'h2
`define PGB_TQ_TRIG             3'h3
`define PGB_TQ_SRC1             3'h4
`define PGB_TQ_SRC8             3'h5
`define PGB_TQ_SRC9             3'h6
`define PGB_TQ_SW_ONLY          3'h7

// Blanking and duty adjustment fields
`define PGB_BLANK_WMASK         16'hfff8
`define PGB_BLANK_LSB           3
`define PGB_EDGE_WMASK          16'h070f
`define PGB_LOW_FALL_BIT        0
`define PGB_LOW_RISE_BIT        1
`define PGB_HIGH_FALL_BIT       2
`define PGB_HIGH_RISE_BIT       3
`define PGB_ROUTE_LSB           8
`define PGB_DUTY_ADJ_WMASK      16'h00ff

// Blanking sub-counter reload; one block counts 7 down to 0, eight generator clocks
`define PGB_BLANK_STEP          3'h7

`endif

// file: verilog/pgb_slice.v
/*
 PWM generator slice: termination qualifier selection, leading-edge blanking,
 generator output routing and timing registers, with an AHB-Lite register slave.
 Assumes one 200 MHz clock, synchronous active-high reset, and a single master
 issuing word transfers; all other inputs are synchronous to the clock.
*/
`timescale 1ns/1ps
`include "pgb_defines.vh"

// How it works
// - Qualifier polarity bit set inverts the selected qualifier, clear passes it.
// - Source code 000 forces the qualifier to one.
// - Source code 111 forces the qualifier to zero; with polarity clear only software bit may qualify.
// - Codes 001/010/011 select duty active, blanking active, generator triggered.
// - Codes 100/101/110 select routed generator output, source 8, source 9.
// - Routing to an absent generator yields constant zero.
// - Low three bits of blanking period ignored; eight-clock resolution.
// - Blanking lasts at least eight clocks when the upper field is zero.
// - Blanking period bits 2..0 read zero and ignore writes.
// - Three-bit selector routes generator 1..8 output as source 1.
// - Routed generator output never touches the blanking counter.
// - High-side rising edge starts blanking when its enable is set.
// - High-side falling edge starts blanking when its enable is set.
// - Low-side rising edge starts blanking when its enable is set.
// - Low-side falling edge starts blanking when its enable is set.
// - Effective duty is duty plus adjustment while protection source active.
// - Unimplemented bits of adjustment and edge registers read zero, ignore writes.
// - Software control mode 10 routes the software bit into termination qualification.
module pgb_slice #(
  parameter NUM_GEN = 8
) (
  // Clock and reset
  input  wire        mclk_in,
  input  wire        sys_rst_in,
  // AHB-Lite slave
  input  wire        hsel_in,
  input  wire [11:0] haddr_in,
  input  wire [1:0]  htrans_in,
  input  wire        hwrite_in,
  input  wire [2:0]  hsize_in,
  input  wire        hready_in,
  input  wire [31:0] hwdata_in,
  output reg  [31:0] hrdata_out,
  output reg         hreadyout_out,
  output reg         hresp_out,
  // Generator signals
  input  wire [7:0]  gen_outputs_in,
  input  wire        high_side_output_in,
  input  wire        low_side_output_in,
  input  wire        duty_active_in,
  input  wire        gen_triggered_in,
  input  wire        pci_source8_in,
  input  wire        pci_source9_in,
  input  wire        pci_source_active_in,
  input  wire        term_event_in,
  input  wire        protect_set_in,
  // Results
  output reg         term_qual_out,
  output reg         blank_active_out,
  output reg         routed_gen_out,
  output reg  [16:0] eff_duty_out,
  output reg  [15:0] phase_value_out,
  output reg  [15:0] period_value_out,
  output reg         protect_latched_out
);

  // Registers
  reg  [15:0] protection_input_ctrl_high_q;
  reg  [15:0] blanking_period_q;
  reg  [15:0] blanking_edge_and_source_sel_q;
  reg  [15:0] generator_phase_q;
  reg  [15:0] generator_duty_q;
  reg  [15:0] duty_adjustment_q;
  reg  [15:0] generator_period_q;

  // Bus state
  reg         wr_pend_q;
  reg  [11:0] wr_addr_q;

  // Blanking and protection state
  reg         high_prev_q;
  reg         low_prev_q;
  reg  [12:0] blank_blocks_q;
  reg  [2:0]  blank_sub_q;
  reg         blank_q;
  reg         protect_q;

  wire        addr_phase = hsel_in & hready_in & htrans_in[1];
  wire [2:0]  tq_src     = protection_input_ctrl_high_q[`PGB_TQ_SRC_LSB +: 3];
  wire        tq_pol     = protection_input_ctrl_high_q[`PGB_TQ_POL_BIT];
  wire        sw_bit     = protection_input_ctrl_high_q[`PGB_SWPC_BIT];
  wire [1:0]  sw_target  = protection_input_ctrl_high_q[`PGB_SWPC_TARGET_LSB +: 2];
  wire [2:0]  route_sel  = blanking_edge_and_source_sel_q[`PGB_ROUTE_LSB +: 3];

  // Per-generator availability mask
  wire [7:0]  gen_present;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_present
      assign gen_present[gi] = (gi < NUM_GEN);
    end
  endgenerate

  wire        routed_d = gen_outputs_in[route_sel] & gen_present[route_sel];

  // Termination qualifier selection
  reg         tq_raw;
  always @* begin
    case (tq_src)
      `PGB_TQ_NONE:    tq_raw = 1'b1;
      `PGB_TQ_DUTY:    tq_raw = duty_active_in;
      `PGB_TQ_BLANK:   tq_raw = blank_q;
      `PGB_TQ_TRIG:    tq_raw = gen_triggered_in;
      `PGB_TQ_SRC1:    tq_raw = routed_d;
      `PGB_TQ_SRC8:    tq_raw = pci_source8_in;
      `PGB_TQ_SRC9:    tq_raw = pci_source9_in;
      `PGB_TQ_SW_ONLY: tq_raw = 1'b0;
      default:         tq_raw = 1'b0;
    endcase
  end

  wire        sw_to_tq = (sw_target == `PGB_SWPC_TARGET_TQ) & sw_bit;
  wire        tq_d     = (tq_raw ^ tq_pol) | sw_to_tq;

  // Output edge detection; routed generator output is deliberately absent here
  wire        edge_hit =
    (blanking_edge_and_source_sel_q[`PGB_HIGH_RISE_BIT] & high_side_output_in & ~high_prev_q) |
    (blanking_edge_and_source_sel_q[`PGB_HIGH_FALL_BIT] & ~high_side_output_in & high_prev_q) |
    (blanking_edge_and_source_sel_q[`PGB_LOW_RISE_BIT] & low_side_output_in & ~low_prev_q) |
    (blanking_edge_and_source_sel_q[`PGB_LOW_FALL_BIT] & ~low_side_output_in & low_prev_q);

  // Read mux
  reg  [15:0] rd_val;
  always @* begin
    case (haddr_in)
      `PGB_OFS_PCI_CTRL_HIGH:  rd_val = protection_input_ctrl_high_q;
      `PGB_OFS_BLANK_PERIOD:   rd_val = blanking_period_q;
      `PGB_OFS_BLANK_EDGE_SEL: rd_val = blanking_edge_and_source_sel_q;
      `PGB_OFS_PHASE:          rd_val = generator_phase_q;
      `PGB_OFS_DUTY:           rd_val = generator_duty_q;
      `PGB_OFS_DUTY_ADJ:       rd_val = duty_adjustment_q;
      `PGB_OFS_PERIOD:         rd_val = generator_period_q;
      `PGB_OFS_STATUS:         rd_val = {13'h0000, protect_q, blank_q, tq_d};
      default:                 rd_val = 16'h0000;
    endcase
  end

  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      protection_input_ctrl_high_q   <= `PGB_RST_VAL;
      blanking_period_q              <= `PGB_RST_VAL;
      blanking_edge_and_source_sel_q <= `PGB_RST_VAL;
      generator_phase_q              <= `PGB_RST_VAL;
      generator_duty_q               <= `PGB_RST_VAL;
      duty_adjustment_q              <= `PGB_RST_VAL;
      generator_period_q             <= `PGB_RST_VAL;
      wr_pend_q                      <= 1'b0;
      wr_addr_q                      <= 12'h000;
      hrdata_out                     <= 32'h00000000;
      hreadyout_out                  <= 1'b1;
      hresp_out                      <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      wr_pend_q     <= addr_phase & hwrite_in;
      if (addr_phase) begin
        wr_addr_q <= haddr_in;
      end
      if (addr_phase & ~hwrite_in) begin
        hrdata_out <= {16'h0000, rd_val};
      end
      if (wr_pend_q) begin
        case (wr_addr_q)
          `PGB_OFS_PCI_CTRL_HIGH:  protection_input_ctrl_high_q   <= hwdata_in[15:0];
          `PGB_OFS_BLANK_PERIOD:   blanking_period_q              <= hwdata_in[15:0] & `PGB_BLANK_WMASK;
          `PGB_OFS_BLANK_EDGE_SEL: blanking_edge_and_source_sel_q <= hwdata_in[15:0] & `PGB_EDGE_WMASK;
          `PGB_OFS_PHASE:          generator_phase_q              <= hwdata_in[15:0];
          `PGB_OFS_DUTY:           generator_duty_q               <= hwdata_in[15:0];
          `PGB_OFS_DUTY_ADJ:       duty_adjustment_q              <= hwdata_in[15:0] & `PGB_DUTY_ADJ_WMASK;
          `PGB_OFS_PERIOD:         generator_period_q             <= hwdata_in[15:0];
          default:                 ;
        endcase
      end
    end
  end

  // Blanking counter: blocks of eight clocks, upper field plus one block
  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      high_prev_q    <= 1'b0;
      low_prev_q     <= 1'b0;
      blank_blocks_q <= 13'h0000;
      blank_sub_q    <= 3'h0;
      blank_q        <= 1'b0;
    end else begin
      high_prev_q <= high_side_output_in;
      low_prev_q  <= low_side_output_in;
      if (edge_hit) begin
        blank_blocks_q <= blanking_period_q[15:`PGB_BLANK_LSB];
        blank_sub_q    <= `PGB_BLANK_STEP;
        blank_q        <= 1'b1;
      end else if (blank_q) begin
        if (blank_sub_q != 3'h0) begin
          blank_sub_q <= blank_sub_q - 3'h1;
        end else if (blank_blocks_q != 13'h0000) begin
          blank_blocks_q <= blank_blocks_q - 13'h0001;
          blank_sub_q    <= `PGB_BLANK_STEP;
        end else begin
          blank_q <= 1'b0;
        end
      end
    end
  end

  // Latched protection condition and registered outputs
  always @(posedge mclk_in) begin
    if (sys_rst_in) begin
      protect_q           <= 1'b0;
      term_qual_out       <= 1'b0;
      blank_active_out    <= 1'b0;
      routed_gen_out      <= 1'b0;
      eff_duty_out        <= 17'h00000;
      phase_value_out     <= 16'h0000;
      period_value_out    <= 16'h0000;
      protect_latched_out <= 1'b0;
    end else begin
      if (protect_set_in) begin
        protect_q <= 1'b1;
      end else if (term_event_in & tq_d) begin
        protect_q <= 1'b0;
      end
      term_qual_out       <= tq_d;
      blank_active_out    <= blank_q;
      routed_gen_out      <= routed_d;
      eff_duty_out        <= pci_source_active_in ?
                             ({1'b0, generator_duty_q} + {9'h000, duty_adjustment_q[7:0]}) :
                             {1'b0, generator_duty_q};
      phase_value_out     <= generator_phase_q;
      period_value_out    <= generator_period_q;
      protect_latched_out <= protect_q;
    end
  end

endmodule // pgb_slice

// file: test/pgb_slice_sva.sv
/* Port assertions for the PWM slice, bound into every instance.
   Assumes zero-wait word writes and outputs registered one clock after their cause. */
`timescale 1ns/1ps
module pgb_slice_sva #(
  parameter NUM_GEN = 8
) (
  // Clock, reset, bus
  input wire logic        mclk_in, sys_rst_in, hsel_in, hwrite_in, hready_in, hreadyout_out, hresp_out,
  input wire logic [11:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic [31:0] hwdata_in,
  // Generator side
  input wire logic [7:0]  gen_outputs_in,
  input wire logic        term_event_in, protect_set_in, term_qual_out, blank_active_out, routed_gen_out,
  input wire logic        protect_latched_out
);
  logic        wr_q, sw, rt;
  logic [11:0] wa_q;
  logic [15:0] ctl_q, edg_q;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  // Shadow of the control and edge registers
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      {wr_q, ctl_q, edg_q} <= '0;
    end else begin
      wr_q <= hsel_in && hready_in && htrans_in[1] && hwrite_in;
      wa_q <= haddr_in;
      if (wr_q && wa_q == 12'h000) ctl_q <= hwdata_in[15:0];
      if (wr_q && wa_q == 12'h008) edg_q <= hwdata_in[15:0];
    end
  end
  assign sw = ctl_q[7] && ctl_q[6:5] == 2'h2;
  assign rt = edg_q[10:8] < NUM_GEN && gen_outputs_in[edg_q[10:8]];
  chk_bus_okay: assert property (hreadyout_out && !hresp_out) else $error("bus not ready");
  chk_qual_none: assert property (ctl_q[2:0] == 3'h0 |=> term_qual_out == (!$past(ctl_q[3]) || $past(sw)))
    else $error("qualifier not one");
  chk_qual_zero: assert property (ctl_q[2:0] == 3'h7 |=> term_qual_out == ($past(ctl_q[3]) || $past(sw)))
    else $error("qualifier not zero");
  chk_route_mux: assert property (1'b1 |=> routed_gen_out == $past(rt)) else $error("bad route");
  chk_blank_min: assert property ($rose(blank_active_out) |-> blank_active_out [*8]) else $error("blank short");
  chk_blank_off: assert property (
    edg_q[3:0] == 4'h0 && $past(edg_q[3:0]) == 4'h0 && $past(edg_q[3:0], 2) == 4'h0 |=> !$rose(blank_active_out))
    else $error("blanking while disabled");
  chk_prot_set: assert property (protect_set_in |-> ##[1:2] protect_latched_out) else $error("not latched");
  chk_prot_clear: assert property ($fell(protect_latched_out) |-> $past(term_event_in) || $past(term_event_in, 2))
    else $error("cleared without termination");
  cov_blank: cover property ($rose(blank_active_out));
  cov_clear: cover property ($fell(protect_latched_out));
  cov_sw: cover property (sw && term_qual_out);
endmodule // pgb_slice_sva

bind pgb_slice pgb_slice_sva #(.NUM_GEN(NUM_GEN)) pgb_slice_sva_inst (.mclk_in, .sys_rst_in, .hsel_in, .hwrite_in,
  .hready_in, .hreadyout_out, .hresp_out, .haddr_in, .htrans_in, .hwdata_in, .gen_outputs_in, .term_event_in,
  .protect_set_in, .term_qual_out, .blank_active_out, .routed_gen_out, .protect_latched_out);

// file: test/pgb_switch_model.sv
/* Switch drive model: gate drivers echo the commanded levels one clock later.
   Assumes commands change just after a rising clock edge. */
`timescale 1ns/1ps
module pgb_switch_model (
  // Clock and commands
  input  wire logic mclk_in,
  input  wire logic hi_cmd_in,
  input  wire logic lo_cmd_in,
  // Drive levels
  output logic      hi_out,
  output logic      lo_out
);
  always @(posedge mclk_in) begin
    hi_out <= hi_cmd_in;
    lo_out <= lo_cmd_in;
  end
endmodule // pgb_switch_model

// file: test/pgb_slice_test.sv
/* Bench for the PWM slice: bus reads queue expected words, a monitor compares them.
   Assumes zero-wait bus answers and the one-clock switch model. */
`timescale 1ns/1ps
module pgb_slice_test;
  logic        mclk_in = 0, sys_rst_in = 1, hsel = 0, hwrite = 0, hi_cmd = 0, lo_cmd = 0, term = 0, pset = 0;
  logic        rd_ph = 0, hi_sw, lo_sw, rdy, blank;
  logic [1:0]  htrans = 0;
  logic [11:0] haddr = 0;
  logic [31:0] hwdata = 0, hrdata, w, rv[9], exp_q[$];
  logic [31:0] m[9] = '{32'h0, 32'hfff8, 32'h070f, 32'hffff, 32'hffff, 32'h00ff, 32'hffff, 32'h0, 32'h0};
  logic [7:0]  gens = 0, sel;
  logic [4:0]  src = 0;
  logic [16:0] eff;
  logic [15:0] per, phs;
  int          failures = 0, n_compared = 0, cyc = 0, seed = 33579, n;

  pgb_slice #(.NUM_GEN(6)) pgb_slice_inst (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hready_in(rdy), .hwdata_in(hwdata),
    .hrdata_out(hrdata), .hreadyout_out(rdy), .hresp_out(), .gen_outputs_in(gens), .high_side_output_in(hi_sw),
    .low_side_output_in(lo_sw), .duty_active_in(src[0]), .gen_triggered_in(src[1]), .pci_source8_in(src[2]),
    .pci_source9_in(src[3]), .pci_source_active_in(src[4]), .term_event_in(term), .protect_set_in(pset),
    .term_qual_out(), .blank_active_out(blank), .routed_gen_out(), .eff_duty_out(eff), .phase_value_out(phs),
    .period_value_out(per), .protect_latched_out());
  pgb_switch_model pgb_switch_model_inst (.mclk_in(mclk_in), .hi_cmd_in(hi_cmd), .lo_cmd_in(lo_cmd),
    .hi_out(hi_sw), .lo_out(lo_sw));

  initial forever #2.5 mclk_in = ~mclk_in;

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want) begin
      failures++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, want);
    end
  endtask

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, wr, a};
    do @(posedge mclk_in); while (rdy !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge mclk_in); while (rdy !== 1'b1);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Read data leave the queue in issue order; cycle ceiling cuts a hang
  always @(posedge mclk_in) begin
    if (rd_ph) chk(hrdata, exp_q.pop_front());
    rd_ph <= hsel && htrans[1] && !hwrite && rdy;
    cyc++;
    if (cyc == 5000) begin
      failures++;
      wrap_up;
    end
  end

  initial begin
    repeat (4) @(posedge mclk_in);
    sys_rst_in <= 0;
    for (int i = 0; i < 9; i++) rd(12'(4 * i), {31'h0, i == 7});
    $display("test reset values done");
    for (int i = 1; i < 9; i++) begin
      w = $random(seed) | 32'h80;
      rv[i] = (i == 7) ? 32'h1 : w & m[i];
      bus(1'b1, 12'(4 * i), w);
      rd(12'(4 * i), rv[i]);
    end
    for (int j = 0; j < 2; j++) begin
      src <= j ? 5'h10 : 5'h00;
      repeat (3) @(posedge mclk_in);
      chk({15'h0, eff}, rv[4] + (j ? rv[5] : 32'h0));
      chk({16'h0, per}, rv[6]);
      chk({16'h0, phs}, rv[3]);
    end
    $display("test registers done");
    for (int c = 0; c < 64; c++) begin
      gens <= 8'($random(seed));
      src <= 5'($random(seed));
      w = $random(seed);
      bus(1'b1, 12'h008, {21'h0, w[10:8], 8'h00});
      bus(1'b1, 12'h000, {24'h0, c[4], c[5] ? 2'h2 : 2'h1, 1'b0, c[3:0]});
      sel = {1'b0, src[3], src[2], w[10:8] < 6 && gens[w[10:8]], src[1], 1'b0, src[0], 1'b1};
      rd(12'h01c, {31'h0, sel[c[2:0]] ^ c[3] | c[5] & c[4]});
    end
    $display("test qualifier done");
    bus(1'b1, 12'h000, 32'h0);
    for (int e = 0; e < 4; e++) begin
      bus(1'b1, 12'h008, 32'h0);
      {hi_cmd, lo_cmd} <= {2{e[0]}};
      bus(1'b1, 12'h004, e[0] ? 32'h13 : 32'h7);
      bus(1'b1, 12'h008, 32'h1 << e);
      if (e[1]) hi_cmd <= !e[0];
      else lo_cmd <= !e[0];
      repeat (6) @(posedge mclk_in);
      chk({31'h0, blank}, 32'h0);
      if (e[1]) hi_cmd <= e[0];
      else lo_cmd <= e[0];
      n = 0;
      repeat (40) @(posedge mclk_in) n += blank;
      chk(n, e[0] ? 32'd24 : 32'd8);
    end
    $display("test blanking done");
    bus(1'b1, 12'h000, 32'h7);
    pset <= 1;
    @(posedge mclk_in);
    {pset, term} <= 2'b01;
    rd(12'h01c, 32'h4);
    bus(1'b1, 12'h000, 32'h0);
    rd(12'h01c, 32'h1);
    $display("test protection done");
    wrap_up;
  end
endmodule // pgb_slice_test
